//--- common/dbg_ctl_defines.svh
`ifndef DBG_CTL_DEFINES_SVH
`define DBG_CTL_DEFINES_SVH

// Register byte offsets
`define OFF_CTRL      12'h000
`define OFF_STATUS    12'h004
`define OFF_PEND      12'h008
`define OFF_CMD       12'h00C
`define OFF_LINK      12'h010

// Control register fields
`define CTRL_RST_MASK     0
`define CTRL_HOT_EN       1
`define CTRL_RAM_INIT     2
`define CTRL_RESET        32'h0000_0000

// Command register fields (write one to act)
`define CMD_BREAK         0
`define CMD_STEP          1
`define CMD_RUN           2
`define CMD_DBG_RESET     3
`define CMD_SW_RESET      4
`define CMD_HOT_ATTACH    5
`define CMD_ATTACH        6

// Link select field position and codes
`define LINK_LSB          0
`define SEL_JTAG          2'h3
`define SEL_ONE_PIN       2'h2
`define SEL_FOUR_PIN      2'h1
`define LINK_RESET        2'h3

// Reset vector default
`define RESET_VECTOR      32'h0000_0000

// Pending flag positions
`define PEND_RESET        0
`define PEND_MASKABLE     1
`define PEND_FAST         2
`define PEND_FLOAT        3

`endif

//--- common/dbg_ctl_pkg.sv
package dbg_ctl_pkg;
	// Core run state, Gray along run -> break -> step
	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_BREAK = 2'b01,
		ST_STEP  = 2'b11
	} core_state_e;
	typedef logic [1:0] link_sel_t;
endpackage

//--- hdl/dbg_reset_irq_mask.sv
// How it works
// - Mask user resets during break or step
// - Debugger reset always applies
// - After debugger reset, all cores break
// - Masked resets pend, run when unmasked
// - Mask interrupts in break and step
// - Masked interrupts pend, serviced after unmask
// - Break entry wakes core from halt
// - Stepped halt breaks at next instruction
// - Stepped deep stop breaks at reset address
// - Program runs from reset vector on connect
// - Select field must match link, else error
// - Hot attach skips RAM init and pin mask
// - Hot attach allows RAM, break, reset only
// - Forced break restores full debug functions
// - Select codes 11 JTAG, 10 one-pin, 01 four-pin
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`include "dbg_ctl_defines.svh"
`default_nettype none
module dbg_reset_irq_mask (
	input  wire logic                  CLK,
	input  wire logic                  RSTN,
	input  wire logic                  PSEL,
	input  wire logic                  PENABLE,
	input  wire logic                  PWRITE,
	input  wire logic [11:0]           PADDR,
	input  wire logic [31:0]           PWDATA,
	output logic [31:0]                PRDATA,
	output logic                       PREADY,
	output logic                       PSLVERR,
	input  wire logic                  USER_RESET_PIN,
	input  wire logic                  USER_SOFT_RESET,
	input  wire logic                  MASKABLE_USER_INTERRUPT,
	input  wire logic                  FAST_MASKABLE_INTERRUPT,
	input  wire logic                  FLOAT_EXCEPTION_INTERRUPT,
	input  wire logic                  HALT_EXEC,
	input  wire logic                  DEEP_STOP_EXEC,
	input  wire logic                  STEP_DONE,
	input  wire logic [31:0]           NEXT_PC,
	input  wire logic                  RESET_TAKEN,
	input  wire logic                  INT_TAKEN,
	input  wire dbg_ctl_pkg::link_sel_t LINK_IN_USE,
	output logic                       CORE_RESET,
	output logic                       CORE_BREAK,
	output logic                       CORE_HALT,
	output logic                       CORE_DEEP_STOP,
	output logic [31:0]                BREAK_PC,
	output logic                       BREAK_PC_LOAD,
	output logic                       INT_MASK,
	output logic [2:0]                 INT_REQ,
	output logic                       RAM_INIT_REQ,
	output logic                       PIN_MASK_EN,
	output logic                       CONNECT_ERROR,
	output logic                       LIMITED_MODE
);
	import dbg_ctl_pkg::*;

	core_state_e      state_reg;
	core_state_e      state_next;
	logic [31:0]      ctrl_reg;
	link_sel_t        sel_reg;
	logic [3:0]       pend_reg;
	logic [3:0]       pend_next;
	logic             hot_reg;
	logic             err_reg;
	logic             attached_reg;
	logic             halt_reg;
	logic             deep_reg;
	logic             rst_out_reg;
	logic [31:0]      bpc_reg;
	logic             bpc_ld_reg;
	logic [31:0]      prdata_reg;
	logic             pin_s1_reg;
	logic             pin_s2_reg;
	logic [2:0]       irq_s1_reg;
	logic [2:0]       irq_s2_reg;
	wire  [2:0]       irq_clr;
	wire  [2:0]       irq_lower;

	// APB decode
	wire        acc       = PSEL && PENABLE;
	wire        wr        = acc && PWRITE;
	wire        hit_ctrl  = PADDR == `OFF_CTRL;
	wire        hit_stat  = PADDR == `OFF_STATUS;
	wire        hit_pend  = PADDR == `OFF_PEND;
	wire        hit_cmd   = PADDR == `OFF_CMD;
	wire        hit_link  = PADDR == `OFF_LINK;
	wire        mapped    = hit_ctrl | hit_stat | hit_pend | hit_cmd
	                      | hit_link;
	wire        cmd_wr    = wr && hit_cmd;

	// Command strobes
	// Several set bits in one write act in the same cycle
	wire        c_break   = cmd_wr && PWDATA[`CMD_BREAK];
	wire        c_step    = cmd_wr && PWDATA[`CMD_STEP];
	wire        c_run     = cmd_wr && PWDATA[`CMD_RUN];
	wire        c_dreset  = cmd_wr && PWDATA[`CMD_DBG_RESET];
	wire        c_sreset  = cmd_wr && PWDATA[`CMD_SW_RESET];
	wire        c_hot     = cmd_wr && PWDATA[`CMD_HOT_ATTACH];
	wire        c_attach  = cmd_wr && PWDATA[`CMD_ATTACH];

	// In limited mode only break, reset and attach commands act
	// Step and run are ignored until a forced break restores them
	wire        full_fn   = !hot_reg;
	wire        step_ok   = c_step && full_fn;
	wire        run_ok    = c_run && full_fn;

	// Attach succeeds only when the select field matches the link
	// A failed attach leaves limited mode as it was
	wire        sel_ok    = sel_reg == LINK_IN_USE;
	wire        hot_ok    = c_hot && ctrl_reg[`CTRL_HOT_EN] && sel_ok;
	wire        link_err  = (c_hot || c_attach) && !sel_ok;
	wire        attach_ok = hot_ok || (c_attach && sel_ok);

	// Masking follows the core state
	// Breaks mask resets whatever the pin-mask bit says
	wire        stopped   = state_reg != ST_RUN;
	wire        rst_mask  = stopped;
	wire        user_rst  = pin_s2_reg || USER_SOFT_RESET;
	wire        rst_req   = user_rst || c_sreset;
	wire        rst_fire  = !rst_mask && (rst_req || pend_reg[`PEND_RESET]);

	// Stepped halt and deep stop become breaks
	// The core never sleeps inside a step
	wire        step_halt = state_reg == ST_STEP && HALT_EXEC;
	wire        step_deep = state_reg == ST_STEP && DEEP_STOP_EXEC;
	wire        step_end  = state_reg == ST_STEP && STEP_DONE;
	wire        to_break  = c_break || step_halt || step_deep || step_end;

	// Service retires one interrupt flag per taken pulse, lowest
	// first, so another waiting source keeps its own flag
	assign irq_lower[0] = 1'b0;
	genvar gi;
	for (gi = 0; gi < 3; gi = gi + 1) begin : g_irq
		if (gi > 0) begin : g_low
			assign irq_lower[gi] = irq_lower[gi-1] | pend_reg[gi];
		end
		assign irq_clr[gi] = INT_TAKEN && !stopped && pend_reg[gi+1]
		                   && !irq_lower[gi];
	end

	// Pending flags: set wins over clear
	always_comb begin
		pend_next = pend_reg;
		if (RESET_TAKEN && !rst_mask)
			pend_next[`PEND_RESET] = 1'b0;
		pend_next[3:1] = pend_next[3:1] & ~irq_clr;
		if (c_dreset)
			pend_next[`PEND_RESET] = 1'b0;
		if (rst_mask && rst_req)
			pend_next[`PEND_RESET] = 1'b1;
		pend_next[3:1] = pend_next[3:1] | irq_s2_reg;
	end

	// Core state transitions
	always_comb begin
		state_next = state_reg;
		case (state_reg)
		ST_RUN: begin
			if (to_break)
				state_next = ST_BREAK;
		end
		ST_BREAK: begin
			if (step_ok)
				state_next = ST_STEP;
			else if (run_ok)
				state_next = ST_RUN;
		end
		ST_STEP: begin
			if (to_break)
				state_next = ST_BREAK;
		end
		default: state_next = ST_BREAK;
		endcase
		if (c_dreset)
			state_next = ST_BREAK;
	end

	// Input synchronisers for pin-level sources
	// Only the second stage is read; the first may still settle
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			pin_s1_reg <= 1'b0;
			pin_s2_reg <= 1'b0;
			irq_s1_reg <= 3'h0;
			irq_s2_reg <= 3'h0;
		end else begin
			pin_s1_reg <= USER_RESET_PIN;
			pin_s2_reg <= pin_s1_reg;
			irq_s1_reg <= {FLOAT_EXCEPTION_INTERRUPT,
			               FAST_MASKABLE_INTERRUPT,
			               MASKABLE_USER_INTERRUPT};
			irq_s2_reg <= irq_s1_reg;
		end
	end

	// State and pending registers
	// Reset leaves the core running from its reset vector
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			state_reg <= ST_RUN;
			pend_reg  <= 4'h0;
		end else begin
			state_reg <= state_next;
			pend_reg  <= pend_next;
		end
	end

	// Reset output: debugger reset ignores the mask
	// A masked user reset waits in its flag and fires on resume
	always_ff @(posedge CLK) begin
		if (!RSTN)
			rst_out_reg <= 1'b0;
		else
			rst_out_reg <= c_dreset || rst_fire;
	end

	// Halt: a break always wakes the core, so leaving run wins
	wire        halt_set  = HALT_EXEC && state_reg == ST_RUN;
	wire        deep_set  = DEEP_STOP_EXEC && state_reg == ST_RUN;
	wire        leave_run = state_next != ST_RUN;
	always_ff @(posedge CLK) begin
		if (!RSTN)
			halt_reg <= 1'b0;
		else if (leave_run)
			halt_reg <= 1'b0;
		else if (halt_set)
			halt_reg <= 1'b1;
	end

	// Deep stop: a core reset ends it as well as a break
	always_ff @(posedge CLK) begin
		if (!RSTN)
			deep_reg <= 1'b0;
		else if (leave_run || rst_out_reg)
			deep_reg <= 1'b0;
		else if (deep_set)
			deep_reg <= 1'b1;
	end

	// Break address load for stepped halt and deep stop
	// Halt resumes at the next instruction, deep stop at reset
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			bpc_reg    <= 32'h0000_0000;
			bpc_ld_reg <= 1'b0;
		end else begin
			bpc_ld_reg <= step_halt || step_deep;
			if (step_deep)
				bpc_reg <= `RESET_VECTOR;
			else if (step_halt)
				bpc_reg <= NEXT_PC;
		end
	end

	// Control register and link select field
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			ctrl_reg <= `CTRL_RESET;
			sel_reg  <= `LINK_RESET;
		end else begin
			if (wr && hit_ctrl)
				ctrl_reg <= PWDATA;
			if (wr && hit_link)
				sel_reg <= PWDATA[`LINK_LSB +: 2];
		end
	end

	// Connection error: a mismatch sets it, a good attach clears it
	always_ff @(posedge CLK) begin
		if (!RSTN)
			err_reg <= 1'b0;
		else if (link_err)
			err_reg <= 1'b1;
		else if (attach_ok)
			err_reg <= 1'b0;
	end

	// Limited mode after hot attach; only a forced break ends it
	always_ff @(posedge CLK) begin
		if (!RSTN)
			hot_reg <= 1'b0;
		else if (hot_ok)
			hot_reg <= 1'b1;
		else if (c_break)
			hot_reg <= 1'b0;
	end

	// Attached flag stays up until the next device reset
	always_ff @(posedge CLK) begin
		if (!RSTN)
			attached_reg <= 1'b0;
		else if (attach_ok)
			attached_reg <= 1'b1;
	end

	// APB read data
	// Captured in setup so the word stands through the access cycle
	wire [31:0] rd_mux = hit_ctrl ? ctrl_reg
	                   : hit_stat ? {25'h0, attached_reg, hot_reg,
	                                 err_reg, halt_reg, deep_reg,
	                                 state_reg}
	                   : hit_pend ? {28'h0, pend_reg}
	                   : hit_link ? {30'h0, sel_reg}
	                   : 32'h0000_0000;
	always_ff @(posedge CLK) begin
		if (!RSTN)
			prdata_reg <= 32'h0000_0000;
		else if (PSEL && !PENABLE && !PWRITE)
			prdata_reg <= rd_mux;
	end

	// Bus answers in the access cycle with no wait
	// Unmapped offsets answer with an error and read as zero
	assign PREADY  = 1'b1;
	assign PSLVERR = acc && !mapped;
	assign PRDATA  = prdata_reg;

	// Outputs to the core
	// Requests wait in their flags while the core is stopped
	assign CORE_RESET     = rst_out_reg;
	assign CORE_BREAK     = stopped;
	assign CORE_HALT      = halt_reg;
	assign CORE_DEEP_STOP = deep_reg;
	assign BREAK_PC       = bpc_reg;
	assign BREAK_PC_LOAD  = bpc_ld_reg;
	assign INT_MASK       = stopped;
	assign INT_REQ        = stopped ? 3'b000 : pend_reg[3:1];
	// Hot attach blocks RAM init and pin masking
	assign RAM_INIT_REQ   = attached_reg && !hot_reg
	                      && ctrl_reg[`CTRL_RAM_INIT];
	assign PIN_MASK_EN    = ctrl_reg[`CTRL_RST_MASK] && !hot_reg;
	assign CONNECT_ERROR  = err_reg;
	assign LIMITED_MODE   = hot_reg;
endmodule
`default_nettype wire

//--- test/core_side_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_side_model (
	input wire logic       CLK,
	input wire logic       RSTN,
	input wire logic       CORE_RESET,
	input wire logic [2:0] INT_REQ,
	output logic           RESET_TAKEN,
	output logic           INT_TAKEN,
	output logic           USER_RESET_PIN
);
	logic [2:0] rst_dly;
	logic [2:0] int_dly;
	// Target never pulls the reset pin while probed
	assign USER_RESET_PIN = 1'b0;
	// Core services a request a few cycles late, so it can be seen
	always_ff @(posedge CLK) begin
		rst_dly <= RSTN ? {rst_dly[1:0], CORE_RESET} : 3'h0;
		int_dly <= RSTN ? {int_dly[1:0], |INT_REQ} : 3'h0;
		RESET_TAKEN <= RSTN && rst_dly[2];
		INT_TAKEN <= RSTN && int_dly[2] && |INT_REQ;
	end
endmodule
`default_nettype wire

//--- test/dbg_mask_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbg_ctl_defines.svh"
module dbg_mask_asserts (
	input wire logic        CLK,
	input wire logic        RSTN,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic        DEEP_STOP_EXEC,
	input wire logic        CORE_RESET,
	input wire logic        CORE_BREAK,
	input wire logic        CORE_HALT,
	input wire logic        CORE_DEEP_STOP,
	input wire logic [31:0] BREAK_PC,
	input wire logic        BREAK_PC_LOAD,
	input wire logic        INT_MASK,
	input wire logic [2:0]  INT_REQ,
	input wire logic        RAM_INIT_REQ,
	input wire logic        PIN_MASK_EN,
	input wire logic        CONNECT_ERROR,
	input wire logic        LIMITED_MODE
);
	logic cmd_wr;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	// Command write landing in its access cycle
	assign cmd_wr = PSEL && PENABLE && PWRITE && PADDR == `OFF_CMD;
	sequence dbg_rst_req;
		cmd_wr && PWDATA[3];
	endsequence
	sequence brk_req;
		cmd_wr && PWDATA[0];
	endsequence
	AST_INT_MASK: assert property (INT_MASK == CORE_BREAK)
		else $error("irq mask differs from break");
	AST_INT_HOLD: assert property (INT_MASK |-> INT_REQ == 3'h0)
		else $error("irq passed while masked");
	AST_DBG_RST: assert property (dbg_rst_req |-> ##[1:2] CORE_RESET)
		else $error("debugger reset lost");
	AST_DBG_BRK: assert property (dbg_rst_req |-> ##[1:3] CORE_BREAK)
		else $error("no break after debugger reset");
	AST_HALT_WAKE: assert property (CORE_BREAK && $past(CORE_BREAK) |-> !CORE_HALT)
		else $error("halted while broken");
	AST_DEEP_NONE: assert property (CORE_BREAK && $past(CORE_BREAK) |-> !CORE_DEEP_STOP)
		else $error("deep stop while broken");
	AST_DEEP_PC: assert property (DEEP_STOP_EXEC && CORE_BREAK |-> ##[1:2] (BREAK_PC_LOAD && BREAK_PC == 32'h0))
		else $error("deep stop step pc");
	AST_ERR_STICKY: assert property (CONNECT_ERROR |=> CONNECT_ERROR)
		else $error("connect error dropped");
	AST_LIM_CLR: assert property (LIMITED_MODE ##0 brk_req |-> ##[1:2] !LIMITED_MODE)
		else $error("break kept limited mode");
	AST_HOT_PIN: assert property (LIMITED_MODE |-> !PIN_MASK_EN && !RAM_INIT_REQ)
		else $error("pin mask or ram init in hot attach");
endmodule
bind dbg_reset_irq_mask dbg_mask_asserts dbg_mask_asserts_i (.CLK, .RSTN,
	.PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .DEEP_STOP_EXEC, .CORE_RESET,
	.CORE_BREAK, .CORE_HALT, .CORE_DEEP_STOP, .BREAK_PC, .BREAK_PC_LOAD,
	.INT_MASK, .INT_REQ, .RAM_INIT_REQ, .PIN_MASK_EN, .CONNECT_ERROR,
	.LIMITED_MODE);
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbg_ctl_defines.svh"
module tb;
	import dbg_ctl_pkg::*;
	logic CLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, USER_RESET_PIN;
	logic USER_SOFT_RESET, HALT_EXEC, DEEP_STOP_EXEC, STEP_DONE;
	logic MASKABLE_USER_INTERRUPT, FAST_MASKABLE_INTERRUPT;
	logic FLOAT_EXCEPTION_INTERRUPT, RESET_TAKEN, INT_TAKEN, CORE_RESET;
	logic CORE_BREAK, CORE_HALT, CORE_DEEP_STOP, BREAK_PC_LOAD, INT_MASK;
	logic RAM_INIT_REQ, PIN_MASK_EN, CONNECT_ERROR, LIMITED_MODE;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA, NEXT_PC, BREAK_PC, rd;
	logic [2:0]  INT_REQ;
	logic        rsp_err;
	link_sel_t   LINK_IN_USE;
	int          miscompares, n_tests, cyc, n_rst, n;
	dbg_reset_irq_mask dbg_reset_irq_mask_i (.CLK, .RSTN, .PSEL, .PENABLE,
		.PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
		.USER_RESET_PIN, .USER_SOFT_RESET, .MASKABLE_USER_INTERRUPT,
		.FAST_MASKABLE_INTERRUPT, .FLOAT_EXCEPTION_INTERRUPT, .HALT_EXEC,
		.DEEP_STOP_EXEC, .STEP_DONE, .NEXT_PC, .RESET_TAKEN, .INT_TAKEN,
		.LINK_IN_USE, .CORE_RESET, .CORE_BREAK, .CORE_HALT,
		.CORE_DEEP_STOP, .BREAK_PC, .BREAK_PC_LOAD, .INT_MASK, .INT_REQ,
		.RAM_INIT_REQ, .PIN_MASK_EN, .CONNECT_ERROR, .LIMITED_MODE);
	core_side_model core_side_model_i (.CLK, .RSTN, .CORE_RESET, .INT_REQ,
		.RESET_TAKEN, .INT_TAKEN, .USER_RESET_PIN);
	initial begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do @(posedge CLK); while (PREADY !== 1'b1);
		rd = PRDATA;
		rsp_err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
	endtask
	task automatic chk(input logic [32:0] got, exp, input string m);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value t=%0t %s", $time, m);
		end
	endtask
	task automatic report_and_stop;
		$display("compares %0d wrong %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Core reset cycles seen, and the hang limit
	always @(negedge CLK) begin
		if (CORE_RESET === 1'b1)
			n_rst++;
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			report_and_stop;
		end
	end
	initial begin
		{RSTN, PSEL, PENABLE, PWRITE, USER_SOFT_RESET, STEP_DONE} = 6'h0;
		{HALT_EXEC, DEEP_STOP_EXEC, MASKABLE_USER_INTERRUPT} = 3'h0;
		{FAST_MASKABLE_INTERRUPT, FLOAT_EXCEPTION_INTERRUPT} = 2'h0;
		{PADDR, PWDATA} = 44'h0;
		NEXT_PC = 32'h0000_1234;
		LINK_IN_USE = `SEL_ONE_PIN;
		repeat (12) @(posedge CLK);
		RSTN <= 1'b1;
		@(posedge CLK);
		apb(0, `OFF_LINK, 0);
		chk(rd, 32'h3, "link reset");
		for (int i = 1; i < 4; i++) begin
			apb(1, `OFF_LINK, 32'(i));
			apb(0, `OFF_LINK, 0);
			chk(rd, 32'(i), "link code");
		end
		apb(0, 12'h020, 0);
		chk({rsp_err, rd}, 33'h1_0000_0000, "unmapped read");
		$display("test link done");
		apb(1, `OFF_CMD, 32'h1);
		chk(INT_MASK, 1, "irq mask in break");
		{MASKABLE_USER_INTERRUPT, FAST_MASKABLE_INTERRUPT} <= 2'h3;
		FLOAT_EXCEPTION_INTERRUPT <= 1'b1;
		repeat (4) @(posedge CLK);
		{MASKABLE_USER_INTERRUPT, FAST_MASKABLE_INTERRUPT} <= 2'h0;
		FLOAT_EXCEPTION_INTERRUPT <= 1'b0;
		chk(INT_REQ, 0, "irq leaked");
		apb(0, `OFF_PEND, 0);
		chk(rd, 32'hE, "irq pending");
		apb(1, `OFF_CMD, 32'h4);
		chk({INT_MASK, INT_REQ}, 4'h7, "irq after run");
		repeat (8) @(posedge CLK);
		apb(0, `OFF_PEND, 0);
		chk(rd, 0, "irq served");
		$display("test irq done");
		apb(1, `OFF_CMD, 32'h1);
		n = n_rst;
		USER_SOFT_RESET <= 1'b1;
		@(posedge CLK);
		USER_SOFT_RESET <= 1'b0;
		apb(0, `OFF_PEND, 0);
		chk({n_rst == n, rd}, 33'h1_0000_0001, "reset pend");
		apb(1, `OFF_CMD, 32'h4);
		repeat (6) @(posedge CLK);
		apb(0, `OFF_PEND, 0);
		chk({n_rst > n, rd}, 33'h1_0000_0000, "reset done");
		apb(1, `OFF_CTRL, 32'h1);
		n = n_rst;
		apb(1, `OFF_CMD, 32'h8);
		chk({n_rst > n, CORE_BREAK}, 2'h3, "debugger reset");
		$display("test reset done");
		apb(1, `OFF_CMD, 32'h4);
		{HALT_EXEC, DEEP_STOP_EXEC} <= 2'h3;
		@(posedge CLK);
		{HALT_EXEC, DEEP_STOP_EXEC} <= 2'h0;
		@(posedge CLK);
		chk({CORE_HALT, CORE_DEEP_STOP}, 2'h3, "sleep in run");
		apb(1, `OFF_CMD, 32'h1);
		chk({CORE_HALT, CORE_DEEP_STOP}, 0, "break wakes");
		for (int k = 0; k < 3; k++) begin
			apb(1, `OFF_CMD, 32'h2);
			HALT_EXEC <= k == 0;
			DEEP_STOP_EXEC <= k == 1;
			STEP_DONE <= k == 2;
			@(posedge CLK);
			{HALT_EXEC, DEEP_STOP_EXEC, STEP_DONE} <= 3'h0;
			repeat (2) @(posedge CLK);
			chk({CORE_HALT, CORE_DEEP_STOP}, 0, "slept in step");
			chk(BREAK_PC, k ? 0 : NEXT_PC, "break pc");
			chk(CORE_BREAK, 1, "step ends in break");
		end
		$display("test step done");
		apb(1, `OFF_CTRL, 32'h7);
		apb(1, `OFF_LINK, 32'h2);
		apb(1, `OFF_CMD, 32'h4);
		apb(1, `OFF_CMD, 32'h20);
		chk({LIMITED_MODE, CORE_BREAK}, 2'h2, "hot attach");
		chk({PIN_MASK_EN, RAM_INIT_REQ}, 0, "hot pins");
		apb(1, `OFF_CMD, 32'h2);
		chk(CORE_BREAK, 0, "step in limited");
		apb(1, `OFF_CMD, 32'h8);
		apb(1, `OFF_CMD, 32'h2);
		apb(0, `OFF_STATUS, 0);
		chk(rd, 32'h61, "reset and step in limited");
		apb(1, `OFF_CMD, 32'h1);
		chk({LIMITED_MODE, CONNECT_ERROR}, 0, "break restores");
		chk({PIN_MASK_EN, RAM_INIT_REQ}, 2'h3, "full mode");
		apb(1, `OFF_CMD, 32'h2);
		apb(0, `OFF_STATUS, 0);
		chk(rd, 32'h43, "step after break");
		apb(1, `OFF_LINK, 32'h1);
		apb(1, `OFF_CMD, 32'h40);
		chk(CONNECT_ERROR, 1, "link mismatch");
		$display("test attach done");
		report_and_stop;
	end
endmodule
`default_nettype wire
